// ===== dv/rsc_smbus_host.sv
/*
  Behavioural management-bus host driving the repeater port.
  Assumes the bench resolves SDA as an open-drain wire with a pull-up.
*/
`timescale 1ns/100ps
module rsc_smbus_host (
  // bus pins
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  localparam realtime Q = 20.0;  // quarter bit, sped up from the 10 to 100 kHz bus

  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // ------------------------------
  // bus conditions
  // ------------------------------
  // offset keeps scl edges off the core clock edges
  task automatic start();
    #1.3;
    sdaLow = 1'b0;
    #Q;
    scl = 1'b1;
    #(2*Q);
    sdaLow = 1'b1;
    #(2*Q);
    scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    #1.3;
    sdaLow = 1'b1;
    #Q;
    scl = 1'b1;
    #(2*Q);
    sdaLow = 1'b0;
    #(2*Q);
  endtask

  // data moves only while scl is low
  task automatic bitx(input logic b, output logic s);
    sdaLow = ~b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // eight bits msb first, then the ninth clock offering last
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], s);
      rx[i] = s;
    end
    bitx(last, s);
    ack = ~s;
  endtask

  // ------------------------------
  // register transactions
  // ------------------------------
  task automatic writeReg(input logic [7:0] dev, ofs, data, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start();
    xfer(dev, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    xfer(data, 1'b1, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // repeated start, then nack on the data byte
  task automatic readReg(input logic [7:0] dev, ofs, output logic [7:0] data,
                         output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, nak;
    start();
    xfer(dev, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    start();
    xfer(dev | 8'h01, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, data, nak);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ===== dv/rsc_smbus_port_bench.sv
/*
  Self-checking bench for the repeater management port.
  Assumes rsc_pkg, rsc_smbus_port and rsc_smbus_host compiled first.
*/
`timescale 1ns/100ps
module rsc_smbus_port_bench;
  import rsc_pkg::*;

  localparam int TMO   = 2000;
  localparam int THIGH = 2000;
  localparam int LIMIT = 90000;

  logic        clk;
  logic        nrst;
  logic        mgmtStrap;
  logic [3:0]  addrStrap;
  logic [7:0]  idleDet;
  logic [7:0]  rateDet;
  logic        scl;
  logic        hostLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        sdaWire;
  logic [3:0]  gpioOut;
  logic [3:0]  gpioOe;
  logic        busIdle;
  logic [31:0] rxBoost;
  logic [63:0] swing;
  logic [63:0] emph;
  int          failCount = 0;
  int          numChecks = 0;
  int          cycles    = 0;
  logic [7:0]  swA [8] = '{8'h10, 8'h17, 8'h1E, 8'h25, 8'h2D, 8'h34, 8'h3B, 8'h42};
  logic [7:0]  deA [8] = '{8'h11, 8'h18, 8'h1F, 8'h26, 8'h2E, 8'h35, 8'h3C, 8'h43};
  logic [7:0]  eqA [4] = '{8'h0F, 8'h16, 8'h1D, 8'h24};

  // open-drain wire with pull-up
  assign sdaWire = ~(hostLow | (sdaOe & ~sdaOut));

  rsc_smbus_port #(.THIGH_CYC(THIGH), .TMO_CYC(TMO)) dut (
    .clk(clk), .nrst(nrst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .mgmtPortSelectStrap(mgmtStrap), .addrStrap(addrStrap), .idleDetect(idleDet),
    .rateDetect(rateDet), .gpioOut(gpioOut), .gpioOe(gpioOe), .busIdle(busIdle),
    .rxBoostLevel(rxBoost), .outputSwing(swing), .txEmphasisCut(emph));

  rsc_smbus_host host (.scl(scl), .sdaLow(hostLow), .sda(sdaWire));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input logic [63:0] got, exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (failCount == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] ofs, data);
    logic ok;
    host.writeReg(8'hA0, ofs, data, ok);
    check(ok, 1'b1);
    waitClk(4);
  endtask

  task automatic rdChk(input logic [7:0] ofs, exp);
    logic [7:0] d;
    logic       ok;
    host.readReg(8'hA0, ofs, d, ok);
    check({ok, d}, {1'b1, exp});
    waitClk(4);
  endtask

  function automatic logic [3:0] pinsExp(input logic [7:0] idl, rt, r47, r4c);
    logic [3:0] p;
    int         a;
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? i : i + 2;
      p[i] = (r47[4] & idl[a]) | (r47[5] & idl[a+2]) | (r4c[6] & rt[a]) | (r4c[7] & rt[a+2]);
    end
    return p;
  endfunction

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic testDefaults();
    check(busIdle, 1'b1);
    check(rxBoost, {4{8'h20}});
    check(swing, {8{8'h03}});
    check(emph, {8{8'h03}});
    check({gpioOe, gpioOut}, 8'h00);
    for (int i = 0; i < NREG; i++) rdChk(REG_OFS[i], REG_RST[i]);
    wr(8'h01, 8'h55);
    rdChk(8'h01, 8'h00);
  endtask

  task automatic testSettings();
    logic [7:0]  code [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
    logic [63:0] deExp;
    for (int c = 0; c < 8; c++) begin
      wr(swA[c], 8'h0F);
      wr(deA[c], code[c % 5]);
      deExp[8*c +: 8] = code[c % 5];
    end
    for (int e = 0; e < 4; e++) wr(eqA[e], 8'h39);
    check(swing, {8{8'h0F}});
    check(emph, deExp);
    check(rxBoost, {4{8'h39}});
    rdChk(8'h43, code[2]);
  endtask

  task automatic testStatus();
    logic [7:0] r47 [4] = '{8'h32, 8'h00, 8'h32, 8'h10};
    logic [7:0] r4c [4] = '{8'h00, 8'hC0, 8'hC0, 8'h80};
    logic [7:0] pat [3] = '{8'h05, 8'hA0, 8'h4A};
    wr(8'h4E, 8'h01);
    check(gpioOe, 4'hF);
    for (int k = 0; k < 4; k++) begin
      wr(8'h47, r47[k]);
      wr(8'h4C, r4c[k]);
      for (int j = 0; j < 3; j++) begin
        @(posedge clk);
        idleDet <= pat[j];
        rateDet <= ~pat[(j+1)%3];
        waitClk(12);
        check(gpioOut, pinsExp(pat[j], ~pat[(j+1)%3], r47[k], r4c[k]));
      end
    end
  endtask

  task automatic testSoftReset();
    wr(8'h00, 8'h01);
    check(swing, {8{8'h03}});
    check(rxBoost, {4{8'h20}});
    check(gpioOe, 4'h0);
    rdChk(8'h00, 8'h00);
  endtask

  task automatic testAddress();
    logic [7:0] devs [3] = '{8'hA2, 8'hB0, 8'hA0};
    logic [3:0] straps [3] = '{4'h1, 4'h8, 4'h0};
    logic [7:0] last;
    logic       ok;
    last = 8'h03;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      addrStrap <= straps[i];
      waitClk(20);
      host.writeReg(devs[(i+1)%3], 8'h10, 8'h1F, ok);
      check(ok, 1'b0);
      check(swing[7:0], last);
      last = 8'(i + 5);
      host.writeReg(devs[i], 8'h10, last, ok);
      check(ok, 1'b1);
      check(swing[7:0], last);
    end
    @(posedge clk);
    mgmtStrap <= 1'b0;
    waitClk(20);
    host.writeReg(8'hA0, 8'h10, 8'h0F, ok);
    check(ok, 1'b0);
    @(posedge clk);
    mgmtStrap <= 1'b1;
    waitClk(20);
  endtask

  task automatic testBusStates();
    logic [7:0] a;
    logic       s;
    a = 8'hA0;
    waitClk(TBUF_CYC + 100);
    check(busIdle, 1'b1);
    host.start();
    waitClk(10);
    check(busIdle, 1'b0);
    host.stop();
    waitClk(TBUF_CYC - 80);
    check(busIdle, 1'b0);
    waitClk(120);
    check(busIdle, 1'b1);
    // clock held low while the address ack is out
    host.start();
    for (int i = 7; i >= 0; i--) host.bitx(a[i], s);
    waitClk(20);
    check(sdaOe, 1'b1);
    check(sdaOut, 1'b0);
    waitClk(TMO + 50);
    check(sdaOe, 1'b0);
    host.bitx(1'b1, s);
    host.stop();
    waitClk(20);
  endtask

  initial begin
    nrst      = 1'b0;
    mgmtStrap = 1'b1;
    addrStrap = 4'h0;
    idleDet   = 8'h00;
    rateDet   = 8'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    waitClk(10);
    testDefaults();
    testSettings();
    testStatus();
    testSoftReset();
    testAddress();
    testBusStates();
    end_of_test();
  end
endmodule

// ===== src/rsc_pkg.sv
/*
  Shared constants for the repeater management port: register map,
  reset values, field positions, bus timing and protocol states.
  Assumes a 250 MHz core clock.
*/
package rsc_pkg;
  localparam int NREG = 24;
  localparam int NCH  = 8;
  localparam int NEQ  = 4;

  // ----------------------------------------------------------------
  // register map, index order
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_OFS [NREG] = '{
    8'h00, 8'h0F, 8'h10, 8'h11, 8'h16, 8'h17, 8'h18, 8'h1D,
    8'h1E, 8'h1F, 8'h24, 8'h25, 8'h26, 8'h2D, 8'h2E, 8'h34,
    8'h35, 8'h3B, 8'h3C, 8'h42, 8'h43, 8'h47, 8'h4C, 8'h4E};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h20, 8'h03, 8'h03, 8'h20, 8'h03, 8'h03, 8'h20,
    8'h03, 8'h03, 8'h20, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
    8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
  localparam int EQ_IDX [NEQ] = '{1, 4, 7, 10};
  localparam int SW_IDX [NCH] = '{2, 5, 8, 11, 13, 15, 17, 19};
  localparam int DE_IDX [NCH] = '{3, 6, 9, 12, 14, 16, 18, 20};
  localparam int IDX_SOFT    = 0;
  localparam int IDX_IDLE_RT = 21;
  localparam int IDX_RATE_RT = 22;
  localparam int IDX_PIN_CFG = 23;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int         SOFT_RST_BIT  = 0;
  localparam logic [7:0] SOFT_RST_KEEP = 8'hFE;
  localparam int         PIN_CFG_BIT   = 0;
  localparam int         IDLE_RT_LO    = 4;
  localparam int         RATE_RT_LO    = 6;
  localparam logic [2:0] ADDR_BASE     = 3'h5;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // ----------------------------------------------------------------
  // synchroniser vector layout
  // ----------------------------------------------------------------
  localparam int          SY_W     = 23;
  localparam int          SY_MODE  = 22;
  localparam int          SY_STRAP = 18;
  localparam int          SY_SCL   = 17;
  localparam int          SY_SDA   = 16;
  localparam int          SY_IDLE  = 8;
  localparam int          SY_RATE  = 0;
  localparam logic [22:0] SYNC_RST = 23'h3_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int TBUF_NS       = 4700;
  localparam int THIGH_MAX_NS  = 50000;
  localparam int TIMEOUT_MS    = 25;
  localparam int TBUF_CYC      = (TBUF_NS * CLK_MHZ + 999) / 1000;
  localparam int THIGH_MAX_CYC = THIGH_MAX_NS * CLK_MHZ / 1000;
  localparam int TIMEOUT_CYC   = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int CNT_W         = 24;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_REG       = 4'h3,
    ST_REG_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_SKIP      = 4'h9
  } rsc_state_t;
endpackage

// ===== src/rsc_smbus_port.sv
/*
  Management-bus slave of a four-lane repeater: address decode, single
  byte register write/read, setting registers, status pin routing.
  Assumes SDA is open drain resolved outside, scl is the bus clock pin,
  and detect inputs come asynchronously from the channels.
*/
`timescale 1ns/100ps
module rsc_smbus_port #(
  parameter int unsigned THIGH_CYC = rsc_pkg::THIGH_MAX_CYC,
  parameter int unsigned TMO_CYC   = rsc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // management bus pins
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // straps
  input  wire logic        mgmtPortSelectStrap,
  input  wire logic [3:0]  addrStrap,
  // channel detect status
  input  wire logic [7:0]  idleDetect,
  input  wire logic [7:0]  rateDetect,
  // status pins
  output logic [3:0]       gpioOut,
  output logic [3:0]       gpioOe,
  output logic             busIdle,
  // settings to the analog path
  output logic [31:0]      rxBoostLevel,
  output logic [63:0]      outputSwing,
  output logic [63:0]      txEmphasisCut
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SY_W-1:0] syA_r, syB_r, syC_r, syQ_r;
  logic [SY_W-1:0] asyncIn;
  assign asyncIn = {mgmtPortSelectStrap, addrStrap, scl, sdaIn, idleDetect, rateDetect};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      syA_r <= SYNC_RST;
      syB_r <= SYNC_RST;
      syC_r <= SYNC_RST;
      syQ_r <= SYNC_RST;
    end else begin
      syA_r <= asyncIn;
      syB_r <= syA_r;
      syC_r <= syB_r;
      // a change counts only once stages two and three agree
      syQ_r <= (syQ_r & (syB_r | syC_r)) | (syB_r & syC_r);
    end
  end

  logic       modeQ, sclQ, sdaQ;
  logic [3:0] strapQ;
  logic [7:0] idleQ, rateQ;
  assign modeQ  = syQ_r[SY_MODE];
  assign strapQ = syQ_r[SY_STRAP +: 4];
  assign sclQ   = syQ_r[SY_SCL];
  assign sdaQ   = syQ_r[SY_SDA];
  assign idleQ  = syQ_r[SY_IDLE +: 8];
  assign rateQ  = syQ_r[SY_RATE +: 8];

  // ----------------------------------------------------------------
  // link domain: bit shifter on the bus clock
  // ----------------------------------------------------------------
  // only read by the core after the eighth falling edge is seen, when
  // it has been still for the whole high phase; no reset needed
  logic [7:0] linkShift_r;
  always_ff @(posedge scl) begin
    linkShift_r <= {linkShift_r[6:0], sdaIn};
  end

  // ----------------------------------------------------------------
  // bus events and timers
  // ----------------------------------------------------------------
  logic sclD_r, sdaD_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclQ;
      sdaD_r <= sdaQ;
    end
  end

  logic sclRise, sclFall, startEv, stopEv;
  assign sclRise = sclQ & ~sclD_r;
  assign sclFall = ~sclQ & sclD_r;
  assign startEv = sclQ & sclD_r & sdaD_r & ~sdaQ;
  assign stopEv  = sclQ & sclD_r & ~sdaD_r & sdaQ;

  logic [CNT_W-1:0] hiCnt_r, lowCnt_r;
  always_ff @(posedge clk) begin
    if (!nrst || !(sclQ && sdaQ)) begin
      hiCnt_r <= '0;
    end else if (hiCnt_r != CNT_W'(THIGH_CYC)) begin
      hiCnt_r <= hiCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || sclQ) begin
      lowCnt_r <= '0;
    end else if (lowCnt_r != CNT_W'(TMO_CYC)) begin
      lowCnt_r <= lowCnt_r + 1'b1;
    end
  end

  logic highTo, tmoEv, freeEv, stopSeen_r, busIdle_r;
  assign highTo = sclQ & sdaQ & (hiCnt_r == CNT_W'(THIGH_CYC - 1));
  assign tmoEv  = ~sclQ & (lowCnt_r == CNT_W'(TMO_CYC - 1));
  assign freeEv = stopSeen_r & sclQ & sdaQ & (hiCnt_r == CNT_W'(TBUF_CYC - 1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stopSeen_r <= 1'b0;
      busIdle_r  <= 1'b1;
    end else begin
      if (stopEv) begin
        stopSeen_r <= 1'b1;
      end else if (startEv || freeEv) begin
        stopSeen_r <= 1'b0;
      end
      if (startEv) begin
        busIdle_r <= 1'b0;
      end else if (freeEv || highTo) begin
        busIdle_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // slave address
  // ----------------------------------------------------------------
  logic [7:0] regMem [NREG];
  logic [3:0] strapLat_r;
  logic [6:0] myAddr;
  logic       pinCfg;
  assign pinCfg = regMem[IDX_PIN_CFG][PIN_CFG_BIT];

  // address straps are frozen once the pins turn into status outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strapLat_r <= 4'h0;
    end else if (!pinCfg) begin
      strapLat_r <= strapQ;
    end
  end
  assign myAddr = {ADDR_BASE, strapLat_r};

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  function automatic logic [5:0] regLookup(input logic [7:0] ofs);
    logic [5:0] res;
    res = 6'h00;
    for (int k = 0; k < NREG; k++) begin
      if (REG_OFS[k] == ofs) begin
        res = {1'b1, 5'(k)};
      end
    end
    return res;
  endfunction

  rsc_state_t  state_r;
  logic [3:0]  bitCnt_r;
  logic [7:0]  ptr_r, rdShift_r, rdByte;
  logic        sdaOe_r, sdaOut_r;
  logic [5:0]  ptrHit;
  logic        abort, byteEnd, wrFire, softFire, addrMatch;

  assign ptrHit    = regLookup(ptr_r);
  assign rdByte    = ptrHit[5] ? regMem[ptrHit[4:0]] : 8'h00;
  assign abort     = !modeQ || tmoEv || highTo || startEv || stopEv;
  assign byteEnd   = sclFall && (bitCnt_r == BYTE_BITS);
  assign addrMatch = linkShift_r[7:1] == myAddr;
  assign wrFire    = !abort && (state_r == ST_WDATA) && byteEnd;
  assign softFire  = wrFire && (ptr_r == REG_OFS[IDX_SOFT]) && linkShift_r[SOFT_RST_BIT];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 4'h0;
      sdaOe_r   <= 1'b0;
      ptr_r     <= 8'h00;
      rdShift_r <= 8'h00;
    end else if (abort) begin
      // registers unreachable out of management mode
      state_r  <= (modeQ && startEv) ? ST_ADDR : ST_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end else begin
      if (sclRise && bitCnt_r != BYTE_BITS) begin
        bitCnt_r <= bitCnt_r + 1'b1;
      end
      // every SDA change happens on a falling SCL edge
      case (state_r)
        ST_ADDR: begin
          if (byteEnd) begin
            if (addrMatch) begin
              state_r <= ST_ADDR_ACK;
              sdaOe_r <= 1'b1;
            end else begin
              state_r <= ST_SKIP;
            end
          end
        end
        ST_REG: begin
          if (byteEnd) begin
            ptr_r   <= linkShift_r;
            state_r <= ST_REG_ACK;
            sdaOe_r <= 1'b1;
          end
        end
        ST_WDATA: begin
          if (byteEnd) begin
            state_r <= ST_WDATA_ACK;
            sdaOe_r <= 1'b1;
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            bitCnt_r <= 4'h0;
            sdaOe_r  <= 1'b0;
            if (state_r == ST_ADDR_ACK && linkShift_r[1]) begin  // ack bit sits below r/w
              state_r   <= ST_RDATA;
              sdaOe_r   <= ~rdByte[7];
              rdShift_r <= {rdByte[6:0], 1'b0};
            end else if (state_r == ST_ADDR_ACK) begin
              state_r <= ST_REG;
            end else begin
              state_r <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (byteEnd) begin
            state_r  <= ST_RDATA_ACK;
            bitCnt_r <= 4'h0;
            sdaOe_r  <= 1'b0;
          end else if (sclFall) begin
            sdaOe_r   <= ~rdShift_r[7];
            rdShift_r <= {rdShift_r[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          if (sclRise && sdaQ) begin
            state_r <= ST_SKIP;
          end else if (sclFall) begin
            state_r   <= ST_RDATA;
            bitCnt_r  <= 4'h0;
            sdaOe_r   <= ~rdByte[7];
            rdShift_r <= {rdByte[6:0], 1'b0};
          end
        end
        ST_IDLE, ST_SKIP: begin
          sdaOe_r <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
          sdaOe_r <= 1'b0;
        end
      endcase
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk) begin
    sdaOut_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softFire) begin
      for (int k = 0; k < NREG; k++) begin
        regMem[k] <= REG_RST[k];
      end
    end else if (wrFire && ptrHit[5]) begin
      // unmapped offsets are acknowledged but dropped
      if (ptrHit[4:0] == 5'(IDX_SOFT)) begin
        regMem[ptrHit[4:0]] <= linkShift_r & SOFT_RST_KEEP;
      end else begin
        regMem[ptrHit[4:0]] <= linkShift_r;
      end
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign outputSwing[8*c +: 8]   = regMem[SW_IDX[c]];
    assign txEmphasisCut[8*c +: 8] = regMem[DE_IDX[c]];
  end
  for (genvar e = 0; e < NEQ; e++) begin : g_eq
    assign rxBoostLevel[8*e +: 8] = regMem[EQ_IDX[e]];
  end

  // ----------------------------------------------------------------
  // status pin routing
  // ----------------------------------------------------------------
  logic [1:0] idleEn, rateEn;
  logic [3:0] gpioOut_r, gpioOe_r;
  assign idleEn = regMem[IDX_IDLE_RT][IDLE_RT_LO +: 2];
  assign rateEn = regMem[IDX_RATE_RT][RATE_RT_LO +: 2];

  // pin p carries channels a and a+2: 0/2, 1/3, 4/6, 5/7
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gpioOut_r <= 4'h0;
      gpioOe_r  <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        gpioOut_r[p] <= (idleEn[0] & idleQ[(p < 2) ? p : p + 2])
                      | (idleEn[1] & idleQ[(p < 2) ? p + 2 : p + 4])
                      | (rateEn[0] & rateQ[(p < 2) ? p : p + 2])
                      | (rateEn[1] & rateQ[(p < 2) ? p + 2 : p + 4]);
      end
      gpioOe_r <= {4{pinCfg}};
    end
  end

  assign sdaOut  = sdaOut_r;
  assign sdaOe   = sdaOe_r;
  assign gpioOut = gpioOut_r;
  assign gpioOe  = gpioOe_r;
  assign busIdle = busIdle_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mode_gate: assert property (!modeQ |=> state_r == ST_IDLE && !sdaOe_r)
    else $error("access outside management mode");
  a_start_addr: assert property (modeQ && startEv |=> state_r == ST_ADDR)
    else $error("start not taken");
  a_stop_idle: assert property (stopEv |=> state_r == ST_IDLE ##1 !sdaOe_r)
    else $error("stop not taken");
  a_addr_ack: assert property (
    !abort && state_r == ST_ADDR && byteEnd && addrMatch
    |=> sdaOe_r && state_r == ST_ADDR_ACK)
    else $error("matching address not acked");
  a_nomatch_skip: assert property (
    !abort && state_r == ST_ADDR && byteEnd && !addrMatch
    |=> state_r == ST_SKIP && !sdaOe_r)
    else $error("foreign address answered");
  a_addr_strap: assert property (
    !pinCfg && $stable(strapQ) |=> myAddr[3:0] == $past(strapQ))
    else $error("strap not in address");
  a_soft_reset: assert property (
    softFire |=> regMem[EQ_IDX[0]] == 8'h20 && regMem[IDX_PIN_CFG] == 8'h00)
    else $error("soft reset missed");
  a_timeout_idle: assert property (tmoEv |=> state_r == ST_IDLE && !sdaOe_r)
    else $error("clock low timeout missed");
  a_pin_dir: assert property (##1 gpioOe_r == {4{$past(pinCfg)}})
    else $error("status pin direction wrong");

  c_write: cover property (wrFire);
  c_read_nack: cover property (state_r == ST_RDATA_ACK && sclRise && sdaQ);
  c_foreign: cover property (state_r == ST_SKIP);
endmodule
